// [verilog/energy_pulse_output_control.sv]
// Energy pulse generation, fault and reverse power flags, APB registers
// Operation
// - Frequency selects scale the power-to-pulse conversion
// - Gain selects give current gain 1/2/8/16
// - Fault high when currents differ over 12.5%
// - Fault clears once mismatch disappears
// - Reverse flag high on negative power
// - Reverse flag not latched, clears on positive
// - Reverse flag changes only with calibration pulse
// - Calibration output pulses at instantaneous power rate
// - Two slow outputs carry average power pulses
// - Enabled filter removes current channel dc
// - Rate select picks calibration pulse frequency
// - Filter on when select high, bypassed low
// - Reset low clears all internal registers except ctrl, which resets to outputs enabled
`timescale 1ns/1ps
`default_nettype none
module energy_pulse_output_control #(
    parameter logic [meter_pkg::ACC_W-1:0] F_THRESH = 44'h000_1000_0000 // Slow pulse energy
) (
    input  wire logic                mclk,
    input  wire logic                arst_n,
    // Converter samples, same clock domain
    input  wire logic                sample_valid,
    input  wire meter_pkg::sample_t  sample,
    // Strap pins, asynchronous
    input  wire logic                freq_select_hi,
    input  wire logic                freq_select_lo,
    input  wire logic                gain_select_hi,
    input  wire logic                gain_select_lo,
    input  wire logic                calibration_rate_select,
    input  wire logic                highpass_select,
    // Logic outputs
    output logic                     calibration_pulse_out,
    output logic                     energy_pulse_a,
    output logic                     energy_pulse_b,
    output logic                     fault,
    output logic                     reverse_power_flag,
    output logic                     irq,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr
);
    localparam int CW = meter_pkg::CUR_W;
    localparam int PW = meter_pkg::POWER_W;
    localparam int AW = meter_pkg::ACC_W;
    localparam int TW = meter_pkg::TIMER_W;
    localparam logic [TW-1:0] CF_CYC = TW'(meter_pkg::CF_PULSE_CYC);
    localparam logic [TW-1:0] F_CYC  = TW'(meter_pkg::F_PULSE_CYC);

    typedef enum logic [1:0] {F_IDLE, F_DRIVE_A, F_DRIVE_B} f_state_t;

    // Strap synchroniser stages
    logic [5:0]           sel_meta_reg;   // First stage, read by second only
    logic [5:0]           sel_sync_reg;   // Second stage
    meter_pkg::select_t   sel;            // Synchronised selects
    // Gain and filtering
    logic [2:0]           gsh;            // Gain shift
    logic signed [CW-1:0] a_ext;
    logic signed [CW-1:0] b_ext;
    logic signed [CW-1:0] a_gain;
    logic signed [CW-1:0] b_gain;
    logic signed [CW-1:0] a_filt;
    logic signed [CW-1:0] b_filt;
    logic                 filt_valid;
    logic signed [meter_pkg::SAMPLE_W-1:0] volt_reg; // Voltage aligned to filter
    // Magnitudes and fault
    logic [CW-1:0]        mag_a_reg;
    logic [CW-1:0]        mag_b_reg;
    logic [CW-1:0]        abs_a;
    logic [CW-1:0]        abs_b;
    logic [CW-1:0]        mag_hi;
    logic [CW-1:0]        mag_lo;
    logic                 use_b;          // Current channel in use
    logic                 fault_next;
    logic                 fault_reg;
    // Power
    logic signed [PW-1:0] pow_inst;
    logic signed [PW-1:0] pow_reg;
    logic signed [PW-1:0] avg_reg;
    logic                 pow_valid_reg;
    logic [PW-1:0]        pow_abs;
    logic [PW-1:0]        avg_abs;
    // Pulse accumulators
    logic [AW-1:0]        cf_acc_reg;
    logic [AW-1:0]        f_acc_reg;
    logic [AW-1:0]        f_th;
    logic [AW-1:0]        cf_th;
    logic [AW-1:0]        cf_sum;
    logic [AW-1:0]        f_sum;
    logic                 cf_fire;
    logic                 f_fire;
    logic                 f_start;
    // Pulse shapers
    logic [TW-1:0]        cf_timer_reg;
    logic [TW-1:0]        f_timer_reg;
    f_state_t             f_state_reg;
    logic                 f_phase_reg;    // Next slow output to drive
    logic                 cf_out_reg;
    logic                 reverse_power_flag_reg;
    // Registers
    logic [31:0]          ctrl_reg;
    meter_pkg::event_t    status_reg;
    meter_pkg::event_t    mask_reg;
    meter_pkg::event_t    events;
    meter_pkg::event_t    rd_clear;       // Bits shown by the read in flight
    logic                 setup_ph;
    logic                 access_ph;
    logic [31:0]          rd_word;
    logic                 rd_err;
    logic                 out_en;

    // Two flops on every strap before any logic sees it
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sel_meta_reg <= '0;
            sel_sync_reg <= '0;
        end else begin
            sel_meta_reg <= {freq_select_hi, freq_select_lo, gain_select_hi,
                             gain_select_lo, calibration_rate_select, highpass_select};
            sel_sync_reg <= sel_meta_reg;
        end
    end
    assign sel = sel_sync_reg;

    // Programmable gain on both current inputs
    assign gsh    = meter_pkg::gain_shift(sel.gain);
    assign a_ext  = {{meter_pkg::GAIN_HEAD{sample.cur_a[meter_pkg::SAMPLE_W-1]}}, sample.cur_a};
    assign b_ext  = {{meter_pkg::GAIN_HEAD{sample.cur_b[meter_pkg::SAMPLE_W-1]}}, sample.cur_b};
    assign a_gain = a_ext <<< gsh;
    assign b_gain = b_ext <<< gsh;

    // Dc removal per current input, switched by the filter select
    dc_blocker #(.W(CW), .SHIFT(meter_pkg::HPF_SHIFT)) u_hpf_a (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .enable    (sel.hpf_on),
        .in_valid  (sample_valid),
        .x         (a_gain),
        .out_valid (filt_valid),
        .y         (a_filt)
    );
    dc_blocker #(.W(CW), .SHIFT(meter_pkg::HPF_SHIFT)) u_hpf_b (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .enable    (sel.hpf_on),
        .in_valid  (sample_valid),
        .x         (b_gain),
        .out_valid (),
        .y         (b_filt)
    );

    // Voltage held so it lines up with the filtered current
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            volt_reg <= '0;
        end else if (sample_valid) begin
            volt_reg <= sample.volt;
        end
    end

    // Smoothed magnitudes; raw samples would flag every zero crossing
    assign abs_a = a_filt[CW-1] ? CW'(-a_filt) : a_filt;
    assign abs_b = b_filt[CW-1] ? CW'(-b_filt) : b_filt;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mag_a_reg <= '0;
            mag_b_reg <= '0;
        end else if (filt_valid) begin
            mag_a_reg <= mag_a_reg + CW'(($signed({1'b0, abs_a}) -
                         $signed({1'b0, mag_a_reg})) >>> meter_pkg::MAG_SHIFT);
            mag_b_reg <= mag_b_reg + CW'(($signed({1'b0, abs_b}) -
                         $signed({1'b0, mag_b_reg})) >>> meter_pkg::MAG_SHIFT);
        end
    end

    // Mismatch test: difference times 8 against the larger input
    assign use_b  = mag_b_reg > mag_a_reg;
    assign mag_hi = use_b ? mag_b_reg : mag_a_reg;
    assign mag_lo = use_b ? mag_a_reg : mag_b_reg;
    assign fault_next = ({3'h0, mag_hi - mag_lo} << meter_pkg::FAULT_SHIFT) >
                        {3'h0, mag_hi};
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            fault_reg <= 1'b0;
        end else begin
            fault_reg <= fault_next;
        end
    end

    // Power from the larger current input
    assign pow_inst = (use_b ? b_filt : a_filt) * volt_reg;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pow_reg       <= '0;
            pow_valid_reg <= 1'b0;
            avg_reg       <= '0;
        end else begin
            pow_valid_reg <= filt_valid;
            if (filt_valid) begin
                pow_reg <= pow_inst;
            end
            // Low pass keeps the real, dc part of the product
            if (pow_valid_reg) begin
                avg_reg <= avg_reg + PW'(($signed({pow_reg[PW-1], pow_reg}) -
                           $signed({avg_reg[PW-1], avg_reg})) >>> meter_pkg::LPF_SHIFT);
            end
        end
    end

    // Thresholds from the frequency and rate selects
    assign f_th  = F_THRESH >> sel.freq;
    assign cf_th = f_th >> (sel.cal_rate ? meter_pkg::CF_SHIFT_HI
                                         : meter_pkg::CF_SHIFT_LO);
    assign pow_abs = pow_reg[PW-1] ? PW'(-pow_reg) : pow_reg;
    assign avg_abs = avg_reg[PW-1] ? PW'(-avg_reg) : avg_reg;
    assign cf_sum  = cf_acc_reg + AW'(pow_abs);
    assign f_sum   = f_acc_reg + AW'(avg_abs);
    assign out_en  = ctrl_reg[meter_pkg::CTRL_EN_BIT];
    assign cf_fire = pow_valid_reg && out_en && (cf_sum >= cf_th);
    assign f_fire  = pow_valid_reg && out_en && (f_sum >= f_th);
    assign f_start = f_fire && (f_state_reg == F_IDLE);

    // Energy accumulators; one pulse per sample at most
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cf_acc_reg <= '0;
            f_acc_reg  <= '0;
        end else if (!out_en) begin
            cf_acc_reg <= '0;
            f_acc_reg  <= '0;
        end else if (pow_valid_reg) begin
            cf_acc_reg <= cf_fire ? cf_sum - cf_th : cf_sum;
            f_acc_reg  <= f_fire ? f_sum - f_th : f_sum;
        end
    end

    // Calibration pulse shaper; a fire during a pulse restarts it
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cf_timer_reg <= '0;
            cf_out_reg   <= 1'b0;
        end else if (cf_fire) begin
            cf_timer_reg <= CF_CYC;
            cf_out_reg   <= 1'b1;
        end else if (cf_timer_reg > TW'(1)) begin
            cf_timer_reg <= cf_timer_reg - TW'(1);
        end else begin
            cf_timer_reg <= '0;
            cf_out_reg   <= 1'b0;
        end
    end

    // Sign of average power sampled only with a calibration pulse
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            reverse_power_flag_reg <= 1'b0;
        end else if (cf_fire) begin
            reverse_power_flag_reg <= avg_reg[PW-1];
        end
    end

    // Slow outputs alternate so a two phase motor steps
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            f_state_reg <= F_IDLE;
            f_timer_reg <= '0;
            f_phase_reg <= 1'b0;
        end else begin
            case (f_state_reg)
                F_IDLE: begin
                    if (f_start) begin
                        f_state_reg <= f_phase_reg ? F_DRIVE_B : F_DRIVE_A;
                        f_timer_reg <= F_CYC;
                    end
                end
                F_DRIVE_A, F_DRIVE_B: begin
                    if (f_timer_reg > TW'(1)) begin
                        f_timer_reg <= f_timer_reg - TW'(1);
                    end else begin
                        f_timer_reg <= '0;
                        f_state_reg <= F_IDLE;
                        f_phase_reg <= ~f_phase_reg;
                    end
                end
                default: begin
                    f_state_reg <= F_IDLE;
                end
            endcase
        end
    end

    // Pin outputs from flops; slow outputs decoded from the state register
    assign calibration_pulse_out = cf_out_reg;
    assign energy_pulse_a        = (f_state_reg == F_DRIVE_A);
    assign energy_pulse_b        = (f_state_reg == F_DRIVE_B);
    assign fault                 = fault_reg;
    assign reverse_power_flag    = reverse_power_flag_reg;

    // Events feeding the sticky status
    assign events.fault_rise = fault_next & ~fault_reg;
    assign events.rev_change = cf_fire & (avg_reg[PW-1] != reverse_power_flag_reg);
    assign events.cf_pulse   = cf_fire;
    assign events.f_pulse    = f_start;

    // APB phases
    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;

    // Read mux, captured in the setup cycle
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_err  = 1'b0;
        case (paddr)
            meter_pkg::OFS_CTRL:   rd_word = ctrl_reg;
            meter_pkg::OFS_STATUS: rd_word = {28'h000_0000, status_reg};
            meter_pkg::OFS_MASK:   rd_word = {28'h000_0000, mask_reg};
            meter_pkg::OFS_LEVEL:  rd_word = {23'h00_0000, sel, use_b, reverse_power_flag_reg, fault_reg};
            meter_pkg::OFS_AVG:    rd_word = avg_reg[PW-1 -: 32];
            default:               rd_err  = 1'b1;
        endcase
    end

    // Read data and error prepared before the access edge
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_word;
            pslverr <= rd_err;
        end
    end
    assign pready = 1'b1;

    // Control and mask writes at the access edge
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= meter_pkg::CTRL_RST;
            mask_reg <= meter_pkg::MASK_RST;
        end else if (access_ph && pwrite) begin
            if (paddr == meter_pkg::OFS_CTRL) begin
                ctrl_reg <= pwdata & 32'h0000_0001;
            end
            if (paddr == meter_pkg::OFS_MASK) begin
                mask_reg <= pwdata[3:0];
            end
        end
    end

    // Read clears only what the snapshot showed; a new event still wins
    assign rd_clear = (access_ph && !pwrite && paddr == meter_pkg::OFS_STATUS)
                      ? prdata[3:0] : 4'h0;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            status_reg <= '0;
        end else begin
            status_reg <= (status_reg & ~rd_clear) | events;
        end
    end

    // Level interrupt while any unmasked status bit is set
    assign irq = |(status_reg & mask_reg);
endmodule
`default_nettype wire

// [verilog/meter_pkg.sv]
// Shared constants, types and helpers for the energy pulse output block
package meter_pkg;
    // Datapath widths
    localparam int SAMPLE_W   = 16;                  // Converter sample width
    localparam int GAIN_HEAD  = 4;                   // Headroom for gain 16
    localparam int CUR_W      = SAMPLE_W + GAIN_HEAD; // Current path width
    localparam int POWER_W    = CUR_W + SAMPLE_W;    // Instantaneous power width
    localparam int ACC_W      = POWER_W + 8;         // Pulse accumulator width

    // Gain codes as left shifts: gain 1, 2, 8, 16
    localparam logic [2:0] GAIN_SH_1  = 3'h0;
    localparam logic [2:0] GAIN_SH_2  = 3'h1;
    localparam logic [2:0] GAIN_SH_8  = 3'h3;
    localparam logic [2:0] GAIN_SH_16 = 3'h4;

    // Filter shifts
    localparam int HPF_SHIFT = 10;                   // DC tracker time constant
    localparam int MAG_SHIFT = 6;                    // Magnitude smoothing
    localparam int LPF_SHIFT = 8;                    // Average power smoothing
    localparam int FAULT_SHIFT = 3;                  // Mismatch limit 1/8 = 12.5%

    // Calibration rate as a divider of the slow threshold
    localparam int CF_SHIFT_LO = 4;                  // Rate select low
    localparam int CF_SHIFT_HI = 7;                  // Rate select high

    // Timing
    localparam int CLK_PERIOD_PS = 4000;             // 250 MHz master clock
    localparam int CF_PULSE_NS   = 100;              // Calibration pulse width
    localparam int F_PULSE_NS    = 2000;             // Slow drive pulse width
    localparam int CF_PULSE_CYC  = (CF_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int F_PULSE_CYC   = (F_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TIMER_W       = 12;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK   = 8'h08;
    localparam logic [7:0] OFS_LEVEL  = 8'h0C;
    localparam logic [7:0] OFS_AVG    = 8'h10;

    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;  // Outputs enabled
    localparam logic [3:0]  MASK_RST = 4'h0;
    localparam int CTRL_EN_BIT = 0;

    // Converter samples, one set per valid strobe
    typedef struct packed {
        logic signed [SAMPLE_W-1:0] cur_a;
        logic signed [SAMPLE_W-1:0] cur_b;
        logic signed [SAMPLE_W-1:0] volt;
    } sample_t;

    // Strap selects after synchronisation
    typedef struct packed {
        logic [1:0] freq;
        logic [1:0] gain;
        logic       cal_rate;
        logic       hpf_on;
    } select_t;

    // Sticky event bits, status and mask share this layout
    typedef struct packed {
        logic f_pulse;
        logic cf_pulse;
        logic rev_change;
        logic fault_rise;
    } event_t;

    // Gain code to shift amount
    function automatic logic [2:0] gain_shift(input logic [1:0] code);
        case (code)
            2'h0:    gain_shift = GAIN_SH_1;
            2'h1:    gain_shift = GAIN_SH_2;
            2'h2:    gain_shift = GAIN_SH_8;
            default: gain_shift = GAIN_SH_16;
        endcase
    endfunction
endpackage

// [verilog/dc_blocker.sv]
// Switchable first order dc removal for one current channel
`timescale 1ns/1ps
`default_nettype none
module dc_blocker #(
    parameter int W     = 20,  // Sample width
    parameter int SHIFT = 10   // Tracker time constant as shift
) (
    input  wire logic                mclk,
    input  wire logic                arst_n,
    input  wire logic                enable,
    input  wire logic                in_valid,
    input  wire logic signed [W-1:0] x,
    output logic                     out_valid,
    output logic signed [W-1:0]      y
);
    logic signed [W+SHIFT-1:0] dc_acc_reg; // Tracked dc, fractional
    logic signed [W-1:0]       dc;         // Integer part of tracked dc
    logic signed [W+SHIFT-1:0] x_ext;      // Input at accumulator width
    logic signed [W+SHIFT-1:0] dc_ext;

    assign dc     = W'(dc_acc_reg >>> SHIFT);
    assign x_ext  = {{SHIFT{x[W-1]}}, x};
    assign dc_ext = {{SHIFT{dc[W-1]}}, dc};

    // Track dc only while enabled so bypass does not leave a stale offset
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            dc_acc_reg <= '0;
        end else if (!enable) begin
            dc_acc_reg <= '0;
        end else if (in_valid) begin
            dc_acc_reg <= dc_acc_reg + x_ext - dc_ext;
        end
    end

    // Output stage, one cycle latency either way; wraps near full scale
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            out_valid <= 1'b0;
            y         <= '0;
        end else begin
            out_valid <= in_valid;
            if (in_valid) begin
                y <= enable ? W'(x - dc) : x;
            end
        end
    end
endmodule
`default_nettype wire

// [tb/energy_pulse_chk.sv]
// Port-level timing checker for the energy pulse block
`timescale 1ns/1ps
`default_nettype none
module energy_pulse_chk (
    input wire logic        mclk,
    input wire logic        arst_n,
    input wire logic        sample_valid,
    input wire logic        calibration_pulse_out,
    input wire logic        energy_pulse_a,
    input wire logic        energy_pulse_b,
    input wire logic        fault,
    input wire logic        reverse_power_flag,
    input wire logic        irq,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    int cf_len;  // High cycles of the running cf pulse
    int a_len;   // High cycles of the running slow pulse on energy_pulse_a
    // Width counters, too long for a repetition operator
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cf_len <= 0;
            a_len  <= 0;
        end else begin
            cf_len <= calibration_pulse_out ? cf_len + 1 : 0;
            a_len  <= energy_pulse_a ? a_len + 1 : 0;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // Setup cycle to an address past the map
    sequence s_bad_setup;
        psel && !penable && paddr > 8'h10;
    endsequence
    a_unmapped_err: assert property (s_bad_setup |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_rev_with_cf: assert property ($changed(reverse_power_flag) |->
        calibration_pulse_out)
        else $error("reverse flag moved without cf pulse");
    a_cf_width: assert property ($fell(calibration_pulse_out) |->
        cf_len >= meter_pkg::CF_PULSE_CYC)
        else $error("cf pulse too short");
    a_slow_width: assert property ($fell(energy_pulse_a) |->
        a_len == meter_pkg::F_PULSE_CYC)
        else $error("slow pulse width wrong");
    a_slow_excl: assert property (!(energy_pulse_a && energy_pulse_b))
        else $error("both slow outputs high");
    a_cf_timing: assert property ($rose(calibration_pulse_out) |->
        $past(sample_valid, 3))
        else $error("cf pulse not three cycles after sample");
    a_fault_timing: assert property ($changed(fault) |-> $past(sample_valid, 3))
        else $error("fault moved off the sample cadence");
    a_pready_high: assert property (pready)
        else $error("pready low");
    a_reset_clear: assert property ($rose(arst_n) |->
        !fault && !irq && !reverse_power_flag)
        else $error("outputs not cleared by reset");
endmodule
bind energy_pulse_output_control energy_pulse_chk u_chk (.mclk(mclk), .arst_n(arst_n),
    .sample_valid(sample_valid), .calibration_pulse_out(calibration_pulse_out),
    .energy_pulse_a(energy_pulse_a), .energy_pulse_b(energy_pulse_b), .fault(fault),
    .reverse_power_flag(reverse_power_flag), .irq(irq), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// [tb/pulse_counter_model.sv]
// Counter and stepper model on the slow and cf outputs
`timescale 1ns/1ps
`default_nettype none
module pulse_counter_model (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic a,
    input wire logic b,
    input wire logic cf,
    output var int   cf_cnt,
    output var int   slow_cnt,
    output var int   alt_err
);
    logic a_q;     // Previous level of a
    logic b_q;     // Previous level of b
    logic cf_q;    // Previous level of cf
    logic last_a;  // Last stepper phase was a
    // Edge counting; a stepper loses a step on a repeated phase
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            {a_q, b_q, cf_q, last_a} <= 4'h0;
            cf_cnt <= 0;
            slow_cnt <= 0;
            alt_err <= 0;
        end else begin
            {a_q, b_q, cf_q} <= {a, b, cf};
            if (cf && !cf_q) begin
                cf_cnt <= cf_cnt + 1;
            end
            if ((a && !a_q) || (b && !b_q)) begin
                slow_cnt <= slow_cnt + 1;
                if ((a && last_a) || (b && !last_a && slow_cnt != 0)) begin
                    alt_err <= alt_err + 1;
                end
                last_a <= a;
            end
        end
    end
endmodule
`default_nettype wire

// [tb/energy_pulse_output_control_tb_top.sv]
// Self-checking bench for the energy pulse block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin errors++; \
    $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module energy_pulse_output_control_tb_top;
    logic mclk = 1'b0;
    logic arst_n, sample_valid, psel, penable, pwrite, pready, pslverr, e;
    logic calibration_pulse_out, energy_pulse_a, energy_pulse_b, fault, reverse_power_flag, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [5:0]  sel;  // Straps {freq, gain, cal rate, filter}
    meter_pkg::sample_t sample;
    int errors = 0, tests_run = 0, seed = 47, c0, c1, cf_cnt, slow_cnt, alt_err;
    energy_pulse_output_control #(.F_THRESH(44'h0_0100_0000)) dut (.mclk(mclk),
        .arst_n(arst_n), .sample_valid(sample_valid), .sample(sample),
        .freq_select_hi(sel[5]), .freq_select_lo(sel[4]), .gain_select_hi(sel[3]),
        .gain_select_lo(sel[2]), .calibration_rate_select(sel[1]), .highpass_select(sel[0]),
        .calibration_pulse_out(calibration_pulse_out), .energy_pulse_a(energy_pulse_a),
        .energy_pulse_b(energy_pulse_b), .fault(fault), .reverse_power_flag(reverse_power_flag),
        .irq(irq), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    pulse_counter_model pm (.mclk(mclk), .arst_n(arst_n), .a(energy_pulse_a), .b(energy_pulse_b),
        .cf(calibration_pulse_out), .cf_cnt(cf_cnt), .slow_cnt(slow_cnt), .alt_err(alt_err));
    // Master clock from outside the block
    initial begin
        forever #2 mclk = ~mclk;
    end
    // Expected strap field of the level register
    function automatic logic [31:0] level_sel(input logic [5:0] s);
        return {23'h0, s, 3'h0};
    endfunction
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // One APB transfer; result lands in q and e
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
        if (n >= 16) begin
            errors++;
            give_verdict();
        end
    endtask
    // Random samples every second cycle; sg sets sign, dv shrinks channel b
    task automatic run(input int n, input int sg, input int dv);
        int v;
        repeat (n) begin
            v = $random(seed) % 100;
            @(posedge mclk);
            sample_valid <= 1'b1;
            sample.volt <= 16'(v);
            sample.cur_a <= 16'(v * sg);
            sample.cur_b <= 16'(v * sg / dv);
            @(posedge mclk);
            sample_valid <= 1'b0;
        end
    endtask
    initial begin
        {arst_n, sample_valid, psel, penable, pwrite, paddr, pwdata, sample} = '0;
        sel = 6'h33;
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        apb(1'b0, 8'h00, 32'h0); `CHK("ctrl", 32'h0000_0001, q)
        apb(1'b0, 8'h08, 32'h0); `CHK("mask", 32'h0000_0000, q)
        apb(1'b0, 8'h20, 32'h0); `CHK("unmapped", 33'h1_0000_0000, {e, q})
        repeat (6) begin
            sel <= 6'($random(seed));
            repeat (3) @(posedge mclk);
            apb(1'b0, 8'h0C, 32'h0); `CHK("sel", level_sel(sel), q & 32'h0000_01F8)
        end
        sel <= 6'h33;
        apb(1'b1, 8'h08, 32'h0000_000F);
        c0 = cf_cnt;
        c1 = slow_cnt;
        run(1500, 1, 1);
        `CHK("cf pulses", 1'b1, cf_cnt > c0)
        `CHK("slow pulses", 1'b1, slow_cnt > c1)
        `CHK("phase order", 0, alt_err)
        `CHK("irq", 1'b1, irq)
        apb(1'b0, 8'h04, 32'h0); `CHK("status cf", 1'b1, q[2])
        apb(1'b1, 8'h08, 32'h0);
        @(posedge mclk); `CHK("irq masked", 1'b0, irq)
        run(1500, -1, 1); `CHK("rev neg", 1'b1, reverse_power_flag)
        run(1500, 1, 1); `CHK("rev pos", 1'b0, reverse_power_flag)
        sel <= 6'h01;
        c0 = cf_cnt;
        run(1500, 1, 1);
        c0 = cf_cnt - c0;
        sel <= 6'h03;
        c1 = cf_cnt;
        run(1500, 1, 1);
        `CHK("rate", 1'b1, cf_cnt - c1 > c0)
        run(800, 1, 2); `CHK("fault set", 1'b1, fault)
        run(800, 1, 1); `CHK("fault clear", 1'b0, fault)
        apb(1'b1, 8'h00, 32'h0);
        @(posedge mclk);
        c0 = cf_cnt;
        run(600, 1, 1); `CHK("disabled", c0, cf_cnt)
        give_verdict();
    end
endmodule
`default_nettype wire
